// ---- hw/ddc2_decim_nco_select.sv ----
// Decimation, input and NCO channel select bank of the second downconverter
`timescale 1ns/1ps
`default_nettype none
module ddc2_decim_nco_select
    import ddc2_cfg_pkg::*;
#(
    parameter int CHAN_W = 4
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic spi_sclk,
    input wire logic spi_csb_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic [2:0] primary_decim_code,
    input wire logic complex_to_real,
    input wire logic side_a_select_pin,
    input wire logic side_b_select_pin,
    output filter_chain_t filter_chain,
    output logic [5:0] decim_ratio,
    output logic decim_valid,
    output logic i_from_b,
    output logic q_from_b,
    output logic [CHAN_W-1:0] nco_channel
);
    // ----------------------------------------------------------------
    // Decimation table lookup
    // ----------------------------------------------------------------
    // The table holds the complex output ratio; complex-to-real halves it,
    // so one entry per code serves both settings.
    function automatic decim_cfg_t decim_decode(
        input logic [2:0] code,
        input logic [3:0] sec,
        input logic c2r
    );
        decim_cfg_t cfg;
        logic [5:0] full;
        cfg = '0;
        full = 6'h00;
        cfg.valid = 1'b1;
        case (code)
            PRI_HB12: {cfg.chain, full} = {6'h03, 6'd4};
            PRI_HB123: {cfg.chain, full} = {6'h07, 6'd8};
            PRI_HB1234: {cfg.chain, full} = {6'h0f, 6'd16};
            PRI_HB1: {cfg.chain, full} = {6'h01, 6'd2};
            PRI_HB1_TB: {cfg.chain, full} = {6'h11, 6'd6};
            PRI_HB12_TB: {cfg.chain, full} = {6'h13, 6'd12};
            PRI_HB123_TB: {cfg.chain, full} = {6'h17, 6'd24};
            default:
            begin
                case (sec)
                    SEC_TB_HB1234: {cfg.chain, full} = {6'h1f, 6'd48};
                    SEC_FB_HB1: {cfg.chain, full} = {6'h21, 6'd10};
                    SEC_FB_HB12: {cfg.chain, full} = {6'h23, 6'd20};
                    SEC_FB_HB123: {cfg.chain, full} = {6'h27, 6'd40};
                    default: cfg.valid = 1'b0;
                endcase
            end
        endcase
        cfg.ratio = c2r ? (full >> 1) : full;
        return cfg;
    endfunction : decim_decode

    // ----------------------------------------------------------------
    // Serial register port
    // ----------------------------------------------------------------
    reg_req_t req;
    logic [7:0] rdata;

    spi_reg_port u_spi (
        .clk(clk),
        .nrst(nrst),
        .spi_sclk(spi_sclk),
        .spi_csb_n(spi_csb_n),
        .spi_sdi(spi_sdi),
        .rdata(rdata),
        .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe),
        .req(req)
    );

    // ----------------------------------------------------------------
    // Register bank
    // ----------------------------------------------------------------
    logic [3:0] sec_decim;
    logic q_sel;
    logic i_sel;
    logic [3:0] nco_mode;
    logic [3:0] map_chan;

    // Address decode shared by write strobes and read mux
    wire hit_insel = req.addr == ADDR_INPUT_SEL;
    wire hit_nco = req.addr == ADDR_NCO_CTRL;
    wire wr_insel = req.wr && hit_insel;
    wire wr_nco = req.wr && hit_nco;

    // Reserved bits read as zero; unmapped addresses read zero too
    wire [7:0] insel_rd = {sec_decim, 1'b0, q_sel, 1'b0, i_sel};
    wire [7:0] nco_rd = {nco_mode, map_chan};
    assign rdata = hit_insel ? insel_rd : (hit_nco ? nco_rd : 8'h00);

    // Writes to reserved bits are dropped
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sec_decim <= RST_INPUT_SEL[INSEL_SEC_LSB +: 4];
            q_sel <= RST_INPUT_SEL[INSEL_Q_BIT];
            i_sel <= RST_INPUT_SEL[INSEL_I_BIT];
        end
        else if (wr_insel)
        begin
            sec_decim <= req.wdata[INSEL_SEC_LSB +: 4];
            q_sel <= req.wdata[INSEL_Q_BIT];
            i_sel <= req.wdata[INSEL_I_BIT];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            nco_mode <= RST_NCO_CTRL[NCO_MODE_LSB +: 4];
            map_chan <= RST_NCO_CTRL[3:0];
        end
        else if (wr_nco)
        begin
            nco_mode <= req.wdata[NCO_MODE_LSB +: 4];
            map_chan <= req.wdata[3:0];
        end
    end

    // ----------------------------------------------------------------
    // Select pin synchronisers and edge detect
    // ----------------------------------------------------------------
    // Bit 1 is the side B pin, bit 0 the side A pin
    logic [1:0] sel_s1;
    logic [1:0] sel_s2;
    logic [1:0] sel_s3;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sel_s1 <= 2'h0;
            sel_s2 <= 2'h0;
            sel_s3 <= 2'h0;
        end
        else
        begin
            sel_s1 <= {side_b_select_pin, side_a_select_pin};
            sel_s2 <= sel_s1;
            sel_s3 <= sel_s2;
        end
    end

    // Pulses narrower than one clock may be missed; the pins are slow
    wire [1:0] sel_rise = sel_s2 & ~sel_s3;

    // ----------------------------------------------------------------
    // Edge-stepped channel counter
    // ----------------------------------------------------------------
    logic [3:0] step_cnt;

    wire step_a = nco_mode == MODE_STEP_A && sel_rise[0];
    wire step_b = nco_mode == MODE_STEP_B && sel_rise[1];
    wire step = step_a || step_b;
    // Lowering the limit below the count also wraps, so it never runs away
    wire at_limit = step_cnt >= map_chan;
    wire [3:0] next_cnt = at_limit ? 4'h0 : step_cnt + 4'h1;

    // A register write wins over a coincident edge so stepping restarts at 0
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            step_cnt <= 4'h0;
        else if (wr_nco)
            step_cnt <= 4'h0;
        else if (step)
            step_cnt <= next_cnt;
    end

    // ----------------------------------------------------------------
    // NCO channel selection
    // ----------------------------------------------------------------
    // Undefined modes fall back to the register map channel
    logic [3:0] next_chan;

    always_comb
    begin
        unique case (nco_mode)
            MODE_PINS: next_chan = {2'b00, sel_s2[1], sel_s2[0]};
            MODE_STEP_A: next_chan = step_cnt;
            MODE_STEP_B: next_chan = step_cnt;
            default: next_chan = map_chan;
        endcase
    end

    wire decim_cfg_t next_cfg = decim_decode(primary_decim_code, sec_decim,
        complex_to_real);

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            filter_chain <= '0;
            decim_ratio <= 6'h00;
            decim_valid <= 1'b0;
            i_from_b <= 1'b0;
            q_from_b <= 1'b0;
            nco_channel <= '0;
        end
        else
        begin
            filter_chain <= next_cfg.chain;
            decim_ratio <= next_cfg.ratio;
            decim_valid <= next_cfg.valid;
            i_from_b <= i_sel;
            q_from_b <= q_sel;
            nco_channel <= CHAN_W'(next_chan);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    prim_101_a: assert property (@(posedge clk) disable iff (!nrst)
        primary_decim_code == 3'h5 |=> filter_chain == 6'h13
        && decim_ratio == ($past(complex_to_real) ? 6'd6 : 6'd12))
        else $error("code 101 chain or ratio wrong");

    prim_110_a: assert property (@(posedge clk) disable iff (!nrst)
        primary_decim_code == 3'h6 |=> filter_chain == 6'h17
        && decim_ratio == ($past(complex_to_real) ? 6'd12 : 6'd24))
        else $error("code 110 chain or ratio wrong");

    sec_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        primary_decim_code != 3'h7 |=> decim_valid
        && !filter_chain.fifth_order_filter)
        else $error("secondary field used without all-ones code");

    sec_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        primary_decim_code == 3'h7 && sec_decim == 4'h0 |=> filter_chain == 6'h1f
        && decim_ratio == ($past(complex_to_real) ? 6'd24 : 6'd48))
        else $error("secondary 0 chain or ratio wrong");

    sec_two_a: assert property (@(posedge clk) disable iff (!nrst)
        primary_decim_code == 3'h7 && sec_decim == 4'h2 |=> filter_chain == 6'h21
        && decim_ratio == ($past(complex_to_real) ? 6'd5 : 6'd10))
        else $error("secondary 2 chain or ratio wrong");

    sec_three_a: assert property (@(posedge clk) disable iff (!nrst)
        primary_decim_code == 3'h7 && sec_decim == 4'h3 |=> filter_chain == 6'h23
        && decim_ratio == ($past(complex_to_real) ? 6'd10 : 6'd20))
        else $error("secondary 3 chain or ratio wrong");

    sec_four_a: assert property (@(posedge clk) disable iff (!nrst)
        primary_decim_code == 3'h7 && sec_decim == 4'h4 |=> filter_chain == 6'h27
        && decim_ratio == ($past(complex_to_real) ? 6'd20 : 6'd40))
        else $error("secondary 4 chain or ratio wrong");

    q_source_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_insel |=> ##1 q_from_b == $past(req.wdata[2], 2))
        else $error("quadrature source not taken from bit 2");

    i_source_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_insel |=> ##1 i_from_b == $past(req.wdata[0], 2) && rdata[3] == 1'b0)
        else $error("in-phase source not taken from bit 0");

    map_chan_a: assert property (@(posedge clk) disable iff (!nrst)
        nco_mode == 4'h0 |=> nco_channel == $past(map_chan))
        else $error("mode 0 channel not the register field");

    pin_chan_a: assert property (@(posedge clk) disable iff (!nrst)
        nco_mode == 4'h1 |=> nco_channel == {2'b00, $past(sel_s2)})
        else $error("mode 1 channel not formed from pins");

    step_a_a: assert property (@(posedge clk) disable iff (!nrst)
        nco_mode == 4'h8 && sel_s2[0] && !sel_s3[0] && !wr_nco
        && step_cnt < map_chan |=> step_cnt == $past(step_cnt) + 4'h1)
        else $error("side A rising edge did not step counter");

    step_b_a: assert property (@(posedge clk) disable iff (!nrst)
        nco_mode == 4'ha && sel_s2[1] && !sel_s3[1] && !wr_nco
        && step_cnt < map_chan |=> step_cnt == $past(step_cnt) + 4'h1)
        else $error("side B rising edge did not step counter");

    wrap_cnt_a: assert property (@(posedge clk) disable iff (!nrst)
        step && !wr_nco && step_cnt == map_chan |=> step_cnt == 4'h0)
        else $error("counter did not wrap at limit");

    hold_cnt_a: assert property (@(posedge clk) disable iff (!nrst)
        !step && !wr_nco |=> $stable(step_cnt))
        else $error("counter moved without an edge");

    clear_cnt_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_nco |=> step_cnt == 4'h0)
        else $error("counter not cleared by control write");

    full_range_a: assert property (@(posedge clk) disable iff (!nrst)
        nco_mode == 4'h0 && map_chan == 4'hf |=> nco_channel == 4'hf)
        else $error("channel 15 not selectable");
endmodule : ddc2_decim_nco_select
`default_nettype wire

// ---- hw/ddc2_cfg_pkg.sv ----
// Shared constants and types for the second downconverter configuration bank
package ddc2_cfg_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam logic [14:0] ADDR_INPUT_SEL = 15'h0351;
    localparam logic [14:0] ADDR_NCO_CTRL = 15'h0354;
    localparam logic [7:0] RST_INPUT_SEL = 8'h00;
    localparam logic [7:0] RST_NCO_CTRL = 8'h00;
    localparam int INSEL_SEC_LSB = 4;
    localparam int INSEL_Q_BIT = 2;
    localparam int INSEL_I_BIT = 0;
    localparam int NCO_MODE_LSB = 4;

    // ----------------------------------------------------------------
    // Decimation codes
    // ----------------------------------------------------------------
    localparam logic [2:0] PRI_HB12 = 3'h0;
    localparam logic [2:0] PRI_HB123 = 3'h1;
    localparam logic [2:0] PRI_HB1234 = 3'h2;
    localparam logic [2:0] PRI_HB1 = 3'h3;
    localparam logic [2:0] PRI_HB1_TB = 3'h4;
    localparam logic [2:0] PRI_HB12_TB = 3'h5;
    localparam logic [2:0] PRI_HB123_TB = 3'h6;
    localparam logic [2:0] PRI_SECONDARY = 3'h7;
    localparam logic [3:0] SEC_TB_HB1234 = 4'h0;
    localparam logic [3:0] SEC_FB_HB1 = 4'h2;
    localparam logic [3:0] SEC_FB_HB12 = 4'h3;
    localparam logic [3:0] SEC_FB_HB123 = 4'h4;

    // ----------------------------------------------------------------
    // NCO channel select modes
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_REGMAP = 4'h0;
    localparam logic [3:0] MODE_PINS = 4'h1;
    localparam logic [3:0] MODE_STEP_A = 4'h8;
    localparam logic [3:0] MODE_STEP_B = 4'ha;

    // ----------------------------------------------------------------
    // Serial port framing
    // ----------------------------------------------------------------
    localparam logic [4:0] SPI_INSTR_LAST = 5'h0f;
    localparam logic [4:0] SPI_FRAME_LAST = 5'h17;
    localparam logic [4:0] SPI_READ_LOAD = 5'h10;

    typedef struct packed {
        logic fifth_order_filter;
        logic third_order_filter;
        logic halfband_stage_four;
        logic halfband_stage_three;
        logic halfband_stage_two;
        logic halfband_stage_one;
    } filter_chain_t;

    typedef struct packed {
        filter_chain_t chain;
        logic [5:0] ratio;
        logic valid;
    } decim_cfg_t;

    typedef struct packed {
        logic wr;
        logic [14:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : ddc2_cfg_pkg

// ---- hw/spi_reg_port.sv ----
// Serial control port slave: samples the pins, issues register writes, serves reads
`timescale 1ns/1ps
`default_nettype none
module spi_reg_port
    import ddc2_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic spi_sclk,
    input wire logic spi_csb_n,
    input wire logic spi_sdi,
    input wire logic [7:0] rdata,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    output reg_req_t req
);
    // ----------------------------------------------------------------
    // Pin synchronisers: bit 2 sclk, bit 1 chip select, bit 0 data in
    // ----------------------------------------------------------------
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic sclk_d;
    logic [4:0] bit_cnt;
    logic [14:0] shift;
    logic read_op;
    logic [7:0] sdo_sh;

    wire sel = ~pin_s2[1];
    wire rise = pin_s2[2] & ~sclk_d;
    wire fall = ~pin_s2[2] & sclk_d;

    // Chip select resets to idle so a reset mid-frame cannot fake a transfer
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_s1 <= 3'h2;
            pin_s2 <= 3'h2;
            sclk_d <= 1'b0;
        end
        else
        begin
            pin_s1 <= {spi_sclk, spi_csb_n, spi_sdi};
            pin_s2 <= pin_s1;
            sclk_d <= pin_s2[2];
        end
    end

    // ----------------------------------------------------------------
    // Frame decoder: one instruction word and one data byte per frame
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_cnt <= 5'h00;
            shift <= 15'h0000;
            read_op <= 1'b0;
            req <= '0;
        end
        else
        begin
            req.wr <= 1'b0;
            if (!sel)
                bit_cnt <= 5'h00;
            else if (rise && bit_cnt <= SPI_FRAME_LAST)
            begin
                shift <= {shift[13:0], pin_s2[0]};
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == SPI_INSTR_LAST)
                begin
                    read_op <= shift[14];
                    req.addr <= {shift[13:0], pin_s2[0]};
                end
                if (bit_cnt == SPI_FRAME_LAST && !read_op)
                begin
                    req.wr <= 1'b1;
                    req.wdata <= {shift[6:0], pin_s2[0]};
                end
            end
        end
    end

    // Read data leaves MSB first, changing on falling sclk
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sdo_sh <= 8'h00;
            spi_sdo_oe <= 1'b0;
        end
        else if (!sel)
            spi_sdo_oe <= 1'b0;
        else if (fall && read_op && bit_cnt == SPI_READ_LOAD)
        begin
            sdo_sh <= rdata;
            spi_sdo_oe <= 1'b1;
        end
        else if (fall && bit_cnt > SPI_READ_LOAD)
            sdo_sh <= {sdo_sh[6:0], 1'b0};
    end

    assign spi_sdo = sdo_sh[7];

    // Only a frame of 24 or more bits may write
    wr_frame_a: assert property (@(posedge clk) disable iff (!nrst)
        req.wr |-> $past(bit_cnt) == SPI_FRAME_LAST && !read_op)
        else $error("write pulse outside a full write frame");
endmodule : spi_reg_port
`default_nettype wire

// ---- tb/gpio_select_model.sv ----
// Partner model: controller that drives the two NCO channel select pins
`timescale 1ns/1ps
`default_nettype none
module gpio_select_model
(
    input wire logic clk,
    output logic side_a_select_pin,
    output logic side_b_select_pin
);
    // Pins idle low until the controller moves them
    initial
    begin
        side_a_select_pin = 1'b0;
        side_b_select_pin = 1'b0;
    end

    // Levels change on a falling edge and are held well past the synchroniser delay
    task automatic set_pins(input logic a, input logic b);
        @(negedge clk);
        side_a_select_pin = a;
        side_b_select_pin = b;
        repeat (5) @(negedge clk);
    endtask : set_pins

    // One clean rising edge on the chosen pin, then back to idle
    task automatic pulse(input logic on_b);
        set_pins(!on_b, on_b);
        set_pins(1'b0, 1'b0);
    endtask : pulse
endmodule : gpio_select_model
`default_nettype wire

// ---- tb/test_ddc2_decim_nco_select.sv ----
// Self-checking bench for the decimation, input and NCO select bank
`timescale 1ns/1ps
`default_nettype none
module test_ddc2_decim_nco_select;
    import ddc2_cfg_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sclk = 1'b0;
    logic csb_n = 1'b1;
    logic sdi = 1'b0;
    logic [2:0] pcode = 3'h7;
    logic c2r = 1'b0;
    logic [7:0] rd;
    logic [7:0] exp_c;
    wire logic sdo, sdo_oe, pin_a, pin_b, dv, ib, qb;
    wire filter_chain_t chain;
    wire logic [5:0] ratio;
    wire logic [3:0] nco;
    int failures = 0;
    int samples_checked = 0;
    // Decimation table: code, secondary, valid with chain, ratio without complex-to-real
    // Every primary code is covered; the last entry is an unused secondary value
    logic [2:0] codes [12] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7, 3'h7,
        3'h7, 3'h7};
    logic [3:0] secs [12] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h0, 4'h2, 4'h3,
        4'h4, 4'h1};
    logic [7:0] chains [12] = '{8'h83, 8'h87, 8'h8f, 8'h81, 8'h91, 8'h93, 8'h97, 8'h9f,
        8'ha1, 8'ha3, 8'ha7, 8'h00};
    logic [7:0] ratios [12] = '{8'h04, 8'h08, 8'h10, 8'h02, 8'h06, 8'h0c, 8'h18, 8'h30,
        8'h0a, 8'h14, 8'h28, 8'h00};

    // Free-running clock
    always #20 clk = ~clk;

    ddc2_decim_nco_select dut (.clk(clk), .nrst(nrst), .spi_sclk(sclk), .spi_csb_n(csb_n),
        .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .primary_decim_code(pcode),
        .complex_to_real(c2r), .side_a_select_pin(pin_a), .side_b_select_pin(pin_b),
        .filter_chain(chain), .decim_ratio(ratio), .decim_valid(dv), .i_from_b(ib),
        .q_from_b(qb), .nco_channel(nco));
    gpio_select_model u_gpio (.clk(clk), .side_a_select_pin(pin_a), .side_b_select_pin(pin_b));

    // ----------------------------------------------------------------
    // Compare and bus tasks
    // ----------------------------------------------------------------
    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask : compare
    task automatic check_out(input logic [7:0] got, input logic [7:0] exp);
        compare(got, exp);
    endtask : check_out
    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        compare(got, exp);
    endtask : check_reg

    // One 24-bit frame; sclk phases are six clocks, above the four the port needs
    task automatic spi_frame(input logic rd_n, input logic [14:0] addr, input logic [7:0] wd);
        logic [23:0] bits;
        bits = {rd_n, addr, wd};
        @(negedge clk);
        csb_n = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            sdi = bits[i];
            repeat (6) @(negedge clk);
            sclk = 1'b1;
            rd[i % 8] = sdo_oe ? sdo : 1'bx;
            repeat (6) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (2) @(negedge clk);
        csb_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask : spi_frame
    task automatic rd_chk(input logic [14:0] addr, input logic [7:0] exp);
        spi_frame(1'b1, addr, 8'h00);
        check_reg(rd, exp);
    endtask : rd_chk

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset;
        rd_chk(ADDR_INPUT_SEL, 8'h00);
        rd_chk(ADDR_NCO_CTRL, 8'h00);
        rd_chk(15'h0352, 8'h00);
        check_out({dv, 1'b0, chain}, 8'h9f);
        check_out({2'h0, ratio}, 8'h30);
    endtask : test_reset
    task automatic test_decim;
        for (int i = 0; i < 12; i++)
            for (int c = 0; c < 2; c++)
            begin
                spi_frame(1'b0, ADDR_INPUT_SEL, {secs[i], 4'hf});
                pcode = codes[i];
                c2r = c[0];
                repeat (2) @(negedge clk);
                check_out({dv, 1'b0, chain}, chains[i]);
                check_out({2'h0, ratio}, ratios[i] >> c);
            end
    endtask : test_decim
    task automatic test_input_sel;
        logic [7:0] v [3] = '{8'h01, 8'h04, 8'h0a};
        for (int i = 0; i < 3; i++)
        begin
            spi_frame(1'b0, ADDR_INPUT_SEL, v[i]);
            check_out({6'h0, qb, ib}, {6'h0, v[i][2], v[i][0]});
            rd_chk(ADDR_INPUT_SEL, v[i] & 8'hf5);
        end
    endtask : test_input_sel
    task automatic test_nco_regmap;
        for (int v = 0; v < 16; v++)
        begin
            spi_frame(1'b0, ADDR_NCO_CTRL, 8'(v));
            check_out({4'h0, nco}, 8'(v));
        end
    endtask : test_nco_regmap
    task automatic test_nco_pins;
        spi_frame(1'b0, ADDR_NCO_CTRL, 8'h1f);
        for (int ab = 0; ab < 4; ab++)
        begin
            u_gpio.set_pins(ab[0], ab[1]);
            check_out({4'h0, nco}, 8'(ab));
        end
        u_gpio.set_pins(1'b0, 1'b0);
    endtask : test_nco_pins
    // Limit of two: counts 1, 2 then wraps; the other pin must not step
    task automatic test_nco_step;
        spi_frame(1'b0, ADDR_NCO_CTRL, 8'h82);
        exp_c = 8'h00;
        check_out({4'h0, nco}, exp_c);
        for (int k = 0; k < 4; k++)
        begin
            u_gpio.pulse(1'b0);
            exp_c = (exp_c >= 8'h02) ? 8'h00 : exp_c + 8'h01;
            check_out({4'h0, nco}, exp_c);
        end
        u_gpio.pulse(1'b1);
        check_out({4'h0, nco}, exp_c);
        spi_frame(1'b0, ADDR_NCO_CTRL, 8'ha2);
        check_out({4'h0, nco}, 8'h00);
        u_gpio.pulse(1'b1);
        check_out({4'h0, nco}, 8'h01);
    endtask : test_nco_step

    // Verdict and the one place the run ends
    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    // Main sequence: reset for 16 clocks, then every scenario in turn
    initial
    begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        test_reset();
        test_decim();
        test_input_sel();
        test_nco_regmap();
        test_nco_pins();
        test_nco_step();
        end_sim();
    end

    // Watchdog: about 52 frames of 300 clocks fit well inside this span
    initial
    begin
        repeat (60000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule : test_ddc2_decim_nco_select
`default_nettype wire
